// ### design/irl_pkg.sv
// Constants and types shared by the interrupt request logic
package irl_pkg;

  // Vector pairs, low byte address of each pair
  localparam logic [9:0] VEC_RESET = 10'h3FE;
  localparam logic [9:0] VEC_SWI   = 10'h3FC;
  localparam logic [9:0] VEC_EXT   = 10'h3FA;
  localparam logic [9:0] VEC_TMR   = 10'h3F8;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_EXT_REQUEST_STATUS_CONTROL  = 10'h00A;
  localparam logic [9:0]  IDX_TIMER_STATUS_CONTROL  = 10'h008;
  localparam logic [11:0] ADDR_EXT_REQUEST_STATUS_CONTROL = {IDX_EXT_REQUEST_STATUS_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_TIMER_STATUS_CONTROL = {IDX_TIMER_STATUS_CONTROL, 2'h0};

  // Request status/control field positions
  localparam int BIT_ENABLE  = 7;
  localparam int BIT_PENDING = 3;
  localparam int BIT_ACK     = 1;

  // Timer status/control view field positions
  localparam int BIT_TOF  = 7;
  localparam int BIT_PERIODIC_TICK_FLAG = 6;
  localparam int BIT_TOIE = 5;
  localparam int BIT_RTIE = 4;

  // Values after reset
  localparam logic RST_ENABLE = 1'b1;
  localparam logic RST_LATCH  = 1'b0;
  // Synchroniser order {reset_pin_n, port_a[3:0], request_pin_n}; idle pin levels
  localparam logic [5:0] RST_SYNC = 6'h21;

  typedef enum logic [2:0] {
    IRL_SRC_NONE,
    IRL_SRC_RESET,
    IRL_SRC_SWI,
    IRL_SRC_EXT,
    IRL_SRC_TMR
  } irl_src_t;

endpackage

// ### design/irl_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module irl_sync
  import irl_pkg::*;
#(
  parameter int         WIDTH     = 6,
  parameter logic [5:0] RESET_VAL = RST_SYNC
) (
  input  wire logic             ref_clk,  // bus clock
  input  wire logic             sys_rst,  // synchronous reset
  input  wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic      [WIDTH-1:0] sync_out  // levels on the clock
);

  logic [WIDTH-1:0] stage1;

  // Stage one feeds stage two only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1   <= RESET_VAL[WIDTH-1:0];
      sync_out <= RESET_VAL[WIDTH-1:0];
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ### design/irl_vector_arbiter.sv
// Picks the source and vector to serve at an instruction boundary
`timescale 1ns/10ps
module irl_vector_arbiter
  import irl_pkg::*;
(
  input  wire logic       reset_req,   // reset vector owed
  input  wire logic       swi_req,     // software trap waiting
  input  wire logic       ext_req,     // external pending and enabled
  input  wire logic       tmr_req,     // timer request active
  input  wire logic       global_mask, // condition code mask bit
  output irl_src_t        src,         // chosen source
  output logic     [9:0]  vector       // chosen vector
);

  // Hardware ahead of the trap, so unmasked pending requests run before it
  always_comb begin
    src    = IRL_SRC_NONE;
    vector = VEC_RESET;
    if (reset_req) begin
      src    = IRL_SRC_RESET;
      vector = VEC_RESET;
    end else if (!global_mask && ext_req) begin
      src    = IRL_SRC_EXT;
      vector = VEC_EXT;
    end else if (!global_mask && tmr_req) begin
      src    = IRL_SRC_TMR;
      vector = VEC_TMR;
    end else if (swi_req) begin
      src    = IRL_SRC_SWI;
      vector = VEC_SWI;
    end
  end

endmodule

// ### design/irl_request_logic.sv
// Interrupt request logic: pin capture, request register, vector selection
`timescale 1ns/10ps
// How it works
// - Any reset selects the reset vector and sets the global mask.
// - The software trap is served whatever the global mask holds.
// - Unmasked hardware requests are served before a waiting software trap.
// - Masked hardware requests are blocked; clearing the mask lets them through.
// - Request pin and enabled port pins merge into one OR feeding the latch.
// - Latch sets when a request pin fall or enabled port pin rise lifts the idle OR.
// - Edge mode: only the latch raises pending, qualified edges only.
// - Level mode: an active OR level also raises pending.
// - Pending starts the external sequence only with enable set.
// - Taking the external vector clears latch and pending.
// - Pending with enable set re-enters the sequence after each return.
// - Unused register bits read zero; reset clears pending, sets enable.
// - Acknowledge one clears the latch, zero does nothing, reads zero.
// - Writes to the pending bit position leave the flag unchanged.
// - Acknowledge in level mode also silences the active level sources.
// - Stop or wait execution sets the enable bit.
// - Setting enable with pending set and mask clear interrupts next boundary.
// - Enable gates port pin requests like the request pin.
// - Port pin levels feed requests whatever their direction.
// - Branch on pin level sees the request pin alone.
// - Timer overflow and tick share one masked timer vector.
// - Several pending hardware requests: highest vector address first.
// - Taking any interrupt waits for instruction end and sets the mask.
module irl_request_logic
  import irl_pkg::*;
(
  input  wire logic        ref_clk,         // bus clock
  input  wire logic        sys_rst,         // synchronous reset
  input  wire logic [11:0] paddr,           // APB address
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB access phase
  input  wire logic        pwrite,          // APB write
  input  wire logic [31:0] pwdata,          // APB write data
  output logic             pready,          // APB ready
  output logic      [31:0] prdata,          // APB read data
  output logic             pslverr,         // APB error
  input  wire logic        reset_pin_n,     // external reset pin
  input  wire logic        internal_reset,  // internal reset sources
  input  wire logic        request_pin_n,   // external request pin
  input  wire logic [3:0]  port_a_low,      // port A bits 3..0 levels
  input  wire logic        level_mode,      // option: edge and level
  input  wire logic        port_irq_on,     // option: port A requests
  input  wire logic        global_mask,     // CPU mask bit
  input  wire logic        instr_done,      // instruction boundary pulse
  input  wire logic        swi_waiting,     // software trap waiting
  input  wire logic        return_done,     // return from interrupt pulse
  input  wire logic        stop_wait_exec,  // stop or wait executed pulse
  input  wire logic        timer_overflow_flag, // timer overflow flag
  input  wire logic        periodic_tick_flag,  // periodic tick flag
  input  wire logic        timer_ovf_enable,    // timer overflow enable
  input  wire logic        tick_enable,         // periodic tick enable
  output logic             vector_take,     // vector fetch pulse
  output logic      [9:0]  vector_addr,     // vector pair address
  output irl_src_t         vector_src,      // source being served
  output logic             set_mask,        // set CPU mask bit
  output logic             pin_level_high,  // request pin level
  output logic             request_pending_flag // pending flag
);

  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_VECTOR} irl_state_t;

  irl_state_t state;
  irl_src_t   arb_src;
  logic [9:0] arb_vec;
  logic [5:0] pins;
  logic       rst_any;
  logic       req_n_s;
  logic [3:0] pa_s;
  logic       or_now;
  logic       or_prev;
  logic       or_rise;
  logic       ext_latch;
  logic       level_inhibit;
  logic       request_enable;
  logic       ext_req;
  logic       tmr_req;
  logic       go;
  logic       take_ext;
  logic       apb_wr;
  logic       apb_setup;
  logic       wr_ext_request_status_control;
  logic       ack_write;
  logic       mapped;

  irl_sync #(
    .WIDTH     (6),
    .RESET_VAL (RST_SYNC)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({reset_pin_n, port_a_low, request_pin_n}),
    .sync_out (pins)
  );

  assign req_n_s = pins[0];
  assign pa_s    = pins[4:1];
  assign rst_any = sys_rst | internal_reset | ~pins[5];

  // Port pins are read at the pad, so direction does not matter
  assign or_now  = ~req_n_s | (port_irq_on & (|pa_s));
  assign or_rise = or_now & ~or_prev;
  assign pin_level_high = req_n_s;

  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      or_prev <= 1'b0;
    end else begin
      or_prev <= or_now;
    end
  end

  // Register bus decode; zero wait states
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign mapped    = (paddr == ADDR_EXT_REQUEST_STATUS_CONTROL) || (paddr == ADDR_TIMER_STATUS_CONTROL);
  assign wr_ext_request_status_control   = apb_wr && (paddr == ADDR_EXT_REQUEST_STATUS_CONTROL);
  assign ack_write = wr_ext_request_status_control & pwdata[BIT_ACK];
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;

  // Pending is the latch, plus the live level in level mode unless silenced
  assign request_pending_flag = ext_latch
                              | (level_mode & or_now & ~level_inhibit);

  assign ext_req  = request_pending_flag & request_enable;
  assign tmr_req  = (timer_overflow_flag & timer_ovf_enable)
                  | (periodic_tick_flag & tick_enable);
  // A return is a boundary too, so a still-pending request re-enters at once
  assign go       = (state == ST_RUN) && (instr_done || return_done)
                  && (arb_src != IRL_SRC_NONE);
  assign take_ext = go && (arb_src == IRL_SRC_EXT);

  // A new edge in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      ext_latch <= RST_LATCH;
    end else if (or_rise) begin
      ext_latch <= 1'b1;
    end else if (take_ext || ack_write) begin
      ext_latch <= 1'b0;
    end
  end

  // Silencing holds until the merged source drops, then re-arms
  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      level_inhibit <= 1'b0;
    end else if (take_ext || ack_write) begin
      level_inhibit <= 1'b1;
    end else if (!or_now) begin
      level_inhibit <= 1'b0;
    end
  end

  // The pending bit position is ignored on writes
  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      request_enable <= RST_ENABLE;
    end else if (stop_wait_exec) begin
      request_enable <= 1'b1;
    end else if (wr_ext_request_status_control) begin
      request_enable <= pwdata[BIT_ENABLE];
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata <= 32'h0000_0000;
      if (paddr == ADDR_EXT_REQUEST_STATUS_CONTROL) begin
        prdata[BIT_ENABLE]  <= request_enable;
        prdata[BIT_PENDING] <= request_pending_flag;
      end else if (paddr == ADDR_TIMER_STATUS_CONTROL) begin
        prdata[BIT_TOF]  <= timer_overflow_flag;
        prdata[BIT_PERIODIC_TICK_FLAG] <= periodic_tick_flag;
        prdata[BIT_TOIE] <= timer_ovf_enable;
        prdata[BIT_RTIE] <= tick_enable;
      end
    end
  end

  irl_vector_arbiter u_arb (
    .reset_req   (state == ST_RESET),
    .swi_req     (swi_waiting),
    .ext_req     (ext_req),
    .tmr_req     (tmr_req),
    .global_mask (global_mask),
    .src         (arb_src),
    .vector      (arb_vec)
  );

  // Sequencer; a return simply lands on a boundary, so pending re-enters
  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      state <= ST_RESET;
    end else begin
      unique case (state)
        ST_RESET:  state <= ST_VECTOR;
        ST_RUN:    if (go) state <= ST_VECTOR;
        ST_VECTOR: state <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      vector_addr <= VEC_RESET;
      vector_src  <= IRL_SRC_RESET;
    end else if (state == ST_RESET) begin
      vector_addr <= VEC_RESET;
      vector_src  <= IRL_SRC_RESET;
    end else if (go) begin
      vector_addr <= arb_vec;
      vector_src  <= arb_src;
    end
  end

  assign vector_take = (state == ST_VECTOR);
  // Mask stays set through reset and every vector fetch
  assign set_mask    = (state != ST_RUN);

  property p_reset_vector;
    @(posedge ref_clk) disable iff (rst_any)
      (state == ST_RESET) |=> vector_take && (vector_addr == VEC_RESET) && set_mask;
  endproperty
  a_reset_vector: assert property (p_reset_vector)
    else $error("reset vector not fetched after reset");

  property p_swi_any_mask;
    @(posedge ref_clk) disable iff (rst_any)
      (state == ST_RUN) && instr_done && swi_waiting && !ext_req && !tmr_req
      |=> vector_take && (vector_addr == VEC_SWI);
  endproperty
  a_swi_any_mask: assert property (p_swi_any_mask)
    else $error("software trap not taken");

  property p_hw_first;
    @(posedge ref_clk) disable iff (rst_any)
      (state == ST_RUN) && instr_done && !global_mask && ext_req
      |=> vector_take && (vector_addr == VEC_EXT) ##1 !vector_take;
  endproperty
  a_hw_first: assert property (p_hw_first)
    else $error("external request not served first");

  property p_masked;
    @(posedge ref_clk) disable iff (rst_any)
      (state == ST_RUN) && instr_done && global_mask && !swi_waiting |=> !vector_take;
  endproperty
  a_masked: assert property (p_masked)
    else $error("hardware request taken while masked");

  property p_latch_edge;
    @(posedge ref_clk) disable iff (rst_any)
      $rose(or_now) |=> ext_latch;
  endproperty
  a_latch_edge: assert property (p_latch_edge)
    else $error("request latch missed an edge");

  property p_edge_only;
    @(posedge ref_clk) disable iff (rst_any)
      !level_mode && !ext_latch |-> !request_pending_flag;
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("pending without latch in edge mode");

  property p_level;
    @(posedge ref_clk) disable iff (rst_any)
      level_mode && !req_n_s && !level_inhibit |-> request_pending_flag;
  endproperty
  a_level: assert property (p_level)
    else $error("low request pin did not raise pending");

  property p_ext_clear;
    @(posedge ref_clk) disable iff (rst_any)
      take_ext && !or_rise |=> !ext_latch && level_inhibit;
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("external vector fetch did not clear request");

  property p_ack_zero;
    @(posedge ref_clk) disable iff (rst_any)
      $past(psel) |-> (prdata[BIT_ACK] == 1'b0) && (prdata[31:8] == 24'h00_0000);
  endproperty
  a_ack_zero: assert property (p_ack_zero)
    else $error("acknowledge or unused bits read nonzero");

  property p_write_keeps;
    @(posedge ref_clk) disable iff (rst_any)
      wr_ext_request_status_control && !pwdata[BIT_ACK] && ext_latch && !take_ext |=> ext_latch;
  endproperty
  a_write_keeps: assert property (p_write_keeps)
    else $error("write changed the pending latch");

  property p_stop_enable;
    @(posedge ref_clk) disable iff (rst_any)
      stop_wait_exec |=> request_enable;
  endproperty
  a_stop_enable: assert property (p_stop_enable)
    else $error("stop or wait did not set enable");

  property p_ack_clears;
    @(posedge ref_clk) disable iff (rst_any)
      ack_write && !or_rise |=> !ext_latch;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledge did not clear the request latch");

  property p_enable_gate;
    @(posedge ref_clk) disable iff (rst_any)
      (state == ST_RUN) && !request_enable && !swi_waiting && !tmr_req |=> !vector_take;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("external request taken with enable clear");

  property p_timer_vec;
    @(posedge ref_clk) disable iff (rst_any)
      (state == ST_RUN) && instr_done && !global_mask && tmr_req && !ext_req
      |=> vector_take && (vector_addr == VEC_TMR);
  endproperty
  a_timer_vec: assert property (p_timer_vec)
    else $error("timer request not served through the timer vector");

  property p_level_ack;
    @(posedge ref_clk) disable iff (rst_any)
      level_mode && ack_write && !or_rise |=> !request_pending_flag;
  endproperty
  a_level_ack: assert property (p_level_ack)
    else $error("acknowledge did not silence the level request");

  property p_reset_state;
    @(posedge ref_clk) disable iff (rst_any)
      (state == ST_RESET) |-> request_enable && !ext_latch;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("request register not at its reset state");

  c_swi:   cover property (@(posedge ref_clk) disable iff (rst_any)
                           vector_take && vector_src == IRL_SRC_SWI);
  c_ext:   cover property (@(posedge ref_clk) disable iff (rst_any)
                           vector_take && vector_src == IRL_SRC_EXT);
  c_tmr:   cover property (@(posedge ref_clk) disable iff (rst_any)
                           vector_take && vector_src == IRL_SRC_TMR);
  c_ack:   cover property (@(posedge ref_clk) disable iff (rst_any)
                           ack_write && level_mode && or_now);
  c_reset: cover property (@(posedge ref_clk) disable iff (rst_any)
                           vector_take && vector_src == IRL_SRC_RESET);

endmodule

// ### tb/irl_cpu_model.sv
// Behavioural model of the CPU sequencer that fetches interrupt vectors
`timescale 1ns/10ps
module irl_cpu_model
  import irl_pkg::*;
(
  input  wire logic       ref_clk,     // bus clock
  input  wire logic       sys_rst,     // synchronous reset
  input  wire logic [3:0] gap,         // boundaries come gap+1 cycles apart, 3 or more
  input  wire logic       clr_mask,    // return from interrupt, clears mask
  input  wire logic       swi_req,     // start a software trap
  input  wire logic       vector_take, // vector fetch pulse
  input  irl_src_t        vector_src,  // source being served
  input  wire logic       set_mask,    // mask set request
  output logic            global_mask, // condition code mask bit
  output logic            instr_done,  // boundary pulse
  output logic            swi_waiting, // trap waiting
  output logic            return_done  // return pulse
);
  logic [3:0] cnt;

  // Restarting at each take keeps boundaries four or more cycles apart
  always_ff @(posedge ref_clk) begin
    if (sys_rst || vector_take) begin
      cnt        <= 4'h0;
      instr_done <= 1'b0;
    end else begin
      cnt        <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
      instr_done <= (cnt >= gap);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || set_mask) begin
      global_mask <= 1'b1;
    end else if (clr_mask) begin
      global_mask <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || (vector_take && vector_src == IRL_SRC_SWI)) begin
      swi_waiting <= 1'b0;
    end else if (swi_req) begin
      swi_waiting <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    return_done <= clr_mask && !sys_rst;
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the interrupt request logic
`timescale 1ns/10ps
module testbench
  import irl_pkg::*;
;
  logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        reset_pin_n, internal_reset, request_pin_n, level_mode, port_irq_on;
  logic [3:0]  port_a_low, gap, tmr;
  logic        global_mask, instr_done, swi_waiting, return_done, stop_wait_exec;
  logic        vector_take, set_mask, pin_level_high, request_pending_flag;
  logic        clr_mask, swi_req;
  logic [9:0]  vector_addr;
  irl_src_t    vector_src;
  int          num_errors, check_count, b;

  irl_request_logic dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .internal_reset(internal_reset),
    .request_pin_n(request_pin_n), .port_a_low(port_a_low), .level_mode(level_mode),
    .port_irq_on(port_irq_on), .global_mask(global_mask), .instr_done(instr_done),
    .swi_waiting(swi_waiting), .return_done(return_done), .stop_wait_exec(stop_wait_exec),
    .timer_overflow_flag(tmr[3]), .periodic_tick_flag(tmr[2]), .timer_ovf_enable(tmr[1]),
    .tick_enable(tmr[0]), .vector_take(vector_take), .vector_addr(vector_addr),
    .vector_src(vector_src), .set_mask(set_mask), .pin_level_high(pin_level_high),
    .request_pending_flag(request_pending_flag));

  irl_cpu_model cpu (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .gap(gap), .clr_mask(clr_mask),
    .swi_req(swi_req), .vector_take(vector_take), .vector_src(vector_src),
    .set_mask(set_mask), .global_mask(global_mask), .instr_done(instr_done),
    .swi_waiting(swi_waiting), .return_done(return_done));

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  function automatic logic [31:0] ext_request_status_control(input logic en, input logic pend);
    ext_request_status_control = 32'h0;
    ext_request_status_control[BIT_ENABLE] = en;
    ext_request_status_control[BIT_PENDING] = pend;
  endfunction

  function automatic irl_src_t src_of(input logic [9:0] va);
    src_of = (va == VEC_RESET) ? IRL_SRC_RESET :
             (va == VEC_SWI)   ? IRL_SRC_SWI   :
             (va == VEC_EXT)   ? IRL_SRC_EXT   : IRL_SRC_TMR;
  endfunction

  function automatic logic [31:0] timer_status_control(input logic [3:0] t);
    timer_status_control = 32'h0;
    timer_status_control[BIT_TOF] = t[3];
    timer_status_control[BIT_PERIODIC_TICK_FLAG] = t[2];
    timer_status_control[BIT_TOIE] = t[1];
    timer_status_control[BIT_RTIE] = t[0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Zero-wait slave, but the master still waits for pready as the bus demands
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] exp);
    apb(1'b0, ADDR_EXT_REQUEST_STATUS_CONTROL, 32'h0);
    check(q, exp);
  endtask

  task automatic take(input logic [9:0] va);
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (vector_take !== 1'b1 && i < 60);
    check(vector_take, 1'b1);
    check(vector_addr, va);
    check(vector_src, src_of(va));
    check(set_mask, 1'b1);
  endtask

  task automatic none(input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (vector_take !== 1'b0) c++;
    end
    check(c, 0);
  endtask

  task automatic unmask;
    @(posedge ref_clk);
    clr_mask <= 1'b1;
    @(posedge ref_clk);
    clr_mask <= 1'b0;
  endtask

  task automatic pin(input logic v, input int n);
    @(posedge ref_clk);
    request_pin_n <= v;
    repeat (n) @(posedge ref_clk);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, internal_reset, level_mode} = '0;
    {port_irq_on, port_a_low, tmr, clr_mask, swi_req, stop_wait_exec} = '0;
    {num_errors, check_count} = '0;
    reset_pin_n = 1'b1;
    request_pin_n = 1'b1;
    sys_rst = 1'b1;
    void'($urandom(31));
    gap = 4'(3 + $urandom % 8);
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    take(VEC_RESET);
    rd(ext_request_status_control(1'b1, 1'b0));
    apb(1'b0, 12'h0FC, 32'h0);
    check(e, 1'b1);
    check(q, 32'h0000_0000);
    tmr <= 4'($urandom);
    apb(1'b0, ADDR_TIMER_STATUS_CONTROL, 32'h0);
    check(q, timer_status_control(tmr));
    tmr <= 4'h0;
    $display("reset and register map done");
    unmask;
    pin(1'b0, 0);
    take(VEC_EXT);
    rd(ext_request_status_control(1'b1, 1'b0));
    pin(1'b1, 3);
    pin(1'b0, 4);
    rd(ext_request_status_control(1'b1, 1'b1));
    none(12);
    unmask;
    take(VEC_EXT);
    pin(1'b1, 3);
    pin(1'b0, 4);
    apb(1'b1, ADDR_EXT_REQUEST_STATUS_CONTROL, 32'h80);
    rd(ext_request_status_control(1'b1, 1'b1));
    apb(1'b1, ADDR_EXT_REQUEST_STATUS_CONTROL, 32'hFF);
    rd(ext_request_status_control(1'b1, 1'b0));
    $display("edge capture and acknowledge done");
    pin(1'b1, 3);
    apb(1'b1, ADDR_EXT_REQUEST_STATUS_CONTROL, 32'h00);
    pin(1'b0, 4);
    rd(ext_request_status_control(1'b0, 1'b1));
    unmask;
    none(15);
    stop_wait_exec <= 1'b1;
    @(posedge ref_clk);
    stop_wait_exec <= 1'b0;
    take(VEC_EXT);
    $display("enable gating done");
    port_irq_on <= 1'b1;
    b = $urandom % 4;
    pin(1'b1, 3);
    port_a_low <= 4'(1 << b);
    repeat (4) @(posedge ref_clk);
    check(pin_level_high, 1'b1);
    unmask;
    take(VEC_EXT);
    port_a_low <= port_a_low | 4'(1 << ((b + 1) % 4));
    repeat (5) @(posedge ref_clk);
    rd(ext_request_status_control(1'b1, 1'b0));
    port_a_low <= 4'h0;
    apb(1'b1, ADDR_EXT_REQUEST_STATUS_CONTROL, 32'h00);
    port_a_low <= 4'(1 << b);
    unmask;
    none(15);
    apb(1'b1, ADDR_EXT_REQUEST_STATUS_CONTROL, 32'h82);
    none(15);
    port_a_low <= 4'h0;
    port_irq_on <= 1'b0;
    $display("port requests done");
    tmr <= 4'hA;
    take(VEC_TMR);
    pin(1'b0, 5);
    // Trap and mask clear land together, so the trap cannot run while masked first
    swi_req  <= 1'b1;
    clr_mask <= 1'b1;
    @(posedge ref_clk);
    swi_req  <= 1'b0;
    clr_mask <= 1'b0;
    take(VEC_EXT);
    take(VEC_SWI);
    unmask;
    take(VEC_TMR);
    tmr <= 4'h0;
    swi_req <= 1'b1;
    @(posedge ref_clk);
    swi_req <= 1'b0;
    take(VEC_SWI);
    $display("priority and trap done");
    level_mode <= 1'b1;
    pin(1'b1, 3);
    pin(1'b0, 4);
    check(request_pending_flag, 1'b1);
    apb(1'b1, ADDR_EXT_REQUEST_STATUS_CONTROL, 32'h02);
    rd(ext_request_status_control(1'b0, 1'b0));
    pin(1'b1, 3);
    internal_reset <= 1'b1;
    @(posedge ref_clk);
    internal_reset <= 1'b0;
    take(VEC_RESET);
    rd(ext_request_status_control(1'b1, 1'b0));
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_pin_n <= 1'b1;
    take(VEC_RESET);
    $display("level mode and resets done");
    report_and_stop;
  end

  initial begin
    #40000;
    num_errors++;
    report_and_stop;
  end
endmodule
